// ===== include/phy_mii_map.svh
`ifndef PHY_MII_MAP_SVH
`define PHY_MII_MAP_SVH
// Word indices; byte address is four times the index
`define IDX_P2_BASIC_CTRL   6'h00
`define IDX_P1_ID_HIGH      6'h06
`define IDX_P1_ADVERTISE    6'h08
`define IDX_P1_PARTNER      6'h0A
`define IDX_P1_CTRL_ALIAS   6'h10
`define IDX_P1_STAT_ALIAS   6'h11
`define IDX_P2_CTRL_ALIAS   6'h12
`define IDX_P2_STAT_ALIAS   6'h13
// Reset values
`define ADV_RESET           5'h1F
`define ADV_RSVD9_RESET     1'b0
`define PARTNER_RESET       5'h00
`define P2_CTRL_RESET       12'h220
`define SELECTOR_FIELD      5'h01
// Advertisement and partner word positions
`define ADV_PAUSE           10
`define ADV_RSVD9           9
`define ADV_FD100           8
`define ADV_HD100           7
`define ADV_FD10            6
`define ADV_HD10            5
// Port 2 basic control positions
`define BC_LOOPBACK         14
`define BC_FORCE100         13
`define BC_AN_EN            12
`define BC_POWER_DOWN       11
`define BC_RESTART          9
`define BC_FULL_DUPLEX      8
`define BC_XSTYLE           5
`define BC_FORCE_MDIX       4
`define BC_DIS_MDIX         3
`define BC_RSVD2            2
`define BC_DIS_TX           1
`define BC_DIS_LED          0
// Port 2 control and status alias positions
`define CA_DIS_LED          15
`define CA_DIS_TX           14
`define CA_RESTART          13
`define CA_RSVD2            12
`define CA_POWER_DOWN       11
`define CA_DIS_MDIX         10
`define CA_FORCE_MDIX       9
`define CA_LOOPBACK         8
`define CA_AN_EN            7
`define CA_FORCE100         6
`define CA_FULL_DUPLEX      5
`define SA_XSTYLE           15
`endif

// ===== include/phy_mii_pkg.sv
`default_nettype none
package phy_mii_pkg;
	typedef struct packed {
		logic pause;
		logic fd100;
		logic hd100;
		logic fd10;
		logic hd10;
	} ability_s;
	typedef struct packed {
		logic loopback;
		logic force_100;
		logic an_enable;
		logic power_down;
		logic restart;
		logic full_duplex;
		logic crossover_style_select;
		logic force_mdix;
		logic disable_mdix;
		logic reserved2;
		logic disable_tx;
		logic disable_led;
	} p2_ctrl_s;
endpackage
`default_nettype wire

// ===== hdl/phy_mii_register_view.sv
`include "phy_mii_map.svh"
`default_nettype none
module phy_mii_register_view #(
	parameter logic [15:0] ID_HIGH = 16'hA5C3 // Value is arbitrary
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic                         wb_ack_o,
	output logic [31:0]                  wb_dat_o,
	input  wire phy_mii_pkg::ability_s   p1_partner_i,
	input  wire logic                    p2_an_failed_i,
	output var phy_mii_pkg::ability_s    adv_o,
	output var phy_mii_pkg::p2_ctrl_s    p2_ctrl_o,
	output logic                         forced_speed_active_o,
	output logic                         forced_speed_100_o,
	output logic                         forced_duplex_active_o,
	output logic                         forced_full_duplex_o
);

	function automatic logic hit(input logic [5:0] a, input logic [5:0] idx);
		return a == idx;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] dat, input logic [1:0] sel);
		return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
	endfunction

	phy_mii_pkg::ability_s  adv_q;
	phy_mii_pkg::ability_s  adv_d;
	phy_mii_pkg::ability_s  partner_q;
	phy_mii_pkg::p2_ctrl_s  p2_q;
	phy_mii_pkg::p2_ctrl_s  p2_d;
	logic                   rsvd9_q;
	logic                   rsvd9_d;
	logic                   ack_q;
	logic [31:0]            dat_q;
	logic                   fsa_q;
	logic                   fs100_q;
	logic                   fda_q;
	logic                   ffd_q;

	wire logic [5:0]  idx      = wb_adr_i[7:2];
	wire logic        req      = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack, never earlier
	wire logic        wr_fire  = req & wb_we_i & ack_q;
	wire logic [1:0]  sel_lo   = wb_sel_i[1:0];
	wire logic [15:0] wdat     = wb_dat_i[15:0];

	// Read views; each stored bit has exactly one flop behind every view
	wire logic [15:0] adv_word = {5'h00, adv_q.pause, rsvd9_q, adv_q.fd100, adv_q.hd100,
		adv_q.fd10, adv_q.hd10, `SELECTOR_FIELD};
	wire logic [15:0] lp_word  = {5'h00, partner_q.pause, 1'b0, partner_q.fd100, partner_q.hd100,
		partner_q.fd10, partner_q.hd10, `SELECTOR_FIELD};
	wire logic [15:0] p1c_word = {11'h000, adv_q};
	wire logic [15:0] p1s_word = {11'h000, partner_q};
	wire logic [15:0] bc_word  = {1'b0, p2_q.loopback, p2_q.force_100, p2_q.an_enable, p2_q.power_down,
		1'b0, p2_q.restart, p2_q.full_duplex, 2'b00, p2_q.crossover_style_select, p2_q.force_mdix,
		p2_q.disable_mdix, p2_q.reserved2, p2_q.disable_tx, p2_q.disable_led};
	wire logic [15:0] p2c_word = {p2_q.disable_led, p2_q.disable_tx, p2_q.restart, p2_q.reserved2,
		p2_q.power_down, p2_q.disable_mdix, p2_q.force_mdix, p2_q.loopback, p2_q.an_enable,
		p2_q.force_100, p2_q.full_duplex, 5'h00};
	wire logic [15:0] p2s_word = {p2_q.crossover_style_select, 15'h0000};

	wire logic [15:0] rd_word  =
		hit(idx, `IDX_P1_ID_HIGH)    ? ID_HIGH  :
		hit(idx, `IDX_P1_ADVERTISE)  ? adv_word :
		hit(idx, `IDX_P1_PARTNER)    ? lp_word  :
		hit(idx, `IDX_P2_BASIC_CTRL) ? bc_word  :
		hit(idx, `IDX_P1_CTRL_ALIAS) ? p1c_word :
		hit(idx, `IDX_P1_STAT_ALIAS) ? p1s_word :
		hit(idx, `IDX_P2_CTRL_ALIAS) ? p2c_word :
		hit(idx, `IDX_P2_STAT_ALIAS) ? p2s_word : 16'h0000;

	wire logic [15:0] w_adv = merge(adv_word, wdat, sel_lo);
	wire logic [15:0] w_p1c = merge(p1c_word, wdat, sel_lo);
	wire logic [15:0] w_bc  = merge(bc_word, wdat, sel_lo);
	wire logic [15:0] w_p2c = merge(p2c_word, wdat, sel_lo);
	wire logic [15:0] w_p2s = merge(p2s_word, wdat, sel_lo);

	always_comb begin
		adv_d = adv_q;
		rsvd9_d = rsvd9_q;
		p2_d = p2_q;
		p2_d.restart = 1'b0;
		if (wr_fire && hit(idx, `IDX_P1_ADVERTISE)) begin
			adv_d.pause = w_adv[`ADV_PAUSE];
			rsvd9_d = w_adv[`ADV_RSVD9];
			adv_d.fd100 = w_adv[`ADV_FD100];
			adv_d.hd100 = w_adv[`ADV_HD100];
			adv_d.fd10 = w_adv[`ADV_FD10];
			adv_d.hd10 = w_adv[`ADV_HD10];
		end
		if (wr_fire && hit(idx, `IDX_P1_CTRL_ALIAS)) begin
			adv_d = w_p1c[4:0];
		end
		if (wr_fire && hit(idx, `IDX_P2_BASIC_CTRL)) begin
			p2_d.loopback = w_bc[`BC_LOOPBACK];
			p2_d.force_100 = w_bc[`BC_FORCE100];
			p2_d.an_enable = w_bc[`BC_AN_EN];
			p2_d.power_down = w_bc[`BC_POWER_DOWN];
			p2_d.restart = w_bc[`BC_RESTART];
			p2_d.full_duplex = w_bc[`BC_FULL_DUPLEX];
			p2_d.crossover_style_select = w_bc[`BC_XSTYLE];
			p2_d.force_mdix = w_bc[`BC_FORCE_MDIX];
			p2_d.disable_mdix = w_bc[`BC_DIS_MDIX];
			p2_d.reserved2 = w_bc[`BC_RSVD2];
			p2_d.disable_tx = w_bc[`BC_DIS_TX];
			p2_d.disable_led = w_bc[`BC_DIS_LED];
		end
		// alias words write the same flops
		if (wr_fire && hit(idx, `IDX_P2_CTRL_ALIAS)) begin
			p2_d.disable_led = w_p2c[`CA_DIS_LED];
			p2_d.disable_tx = w_p2c[`CA_DIS_TX];
			p2_d.restart = w_p2c[`CA_RESTART];
			p2_d.reserved2 = w_p2c[`CA_RSVD2];
			p2_d.power_down = w_p2c[`CA_POWER_DOWN];
			p2_d.disable_mdix = w_p2c[`CA_DIS_MDIX];
			p2_d.force_mdix = w_p2c[`CA_FORCE_MDIX];
			p2_d.loopback = w_p2c[`CA_LOOPBACK];
			p2_d.an_enable = w_p2c[`CA_AN_EN];
			p2_d.force_100 = w_p2c[`CA_FORCE100];
			p2_d.full_duplex = w_p2c[`CA_FULL_DUPLEX];
		end
		if (wr_fire && hit(idx, `IDX_P2_STAT_ALIAS)) begin
			p2_d.crossover_style_select = w_p2s[`SA_XSTYLE];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adv_q <= `ADV_RESET;
			rsvd9_q <= `ADV_RSVD9_RESET;
			p2_q <= `P2_CTRL_RESET;
		end else begin
			adv_q <= adv_d;
			rsvd9_q <= rsvd9_d;
			p2_q <= p2_d;
		end
	end

	// partner word sampled from negotiation engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			partner_q <= `PARTNER_RESET;
		end else begin
			partner_q <= p1_partner_i;
		end
	end

	// One wait state; ack drops the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			dat_q <= (req & ~ack_q & ~wb_we_i) ? {16'h0000, rd_word} : 32'h0000_0000;
		end
	end

	// forced settings gated by negotiation state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fsa_q <= 1'b0;
			fs100_q <= 1'b0;
			fda_q <= 1'b0;
			ffd_q <= 1'b0;
		end else begin
			fsa_q <= ~p2_q.an_enable;
			fs100_q <= ~p2_q.an_enable & p2_q.force_100;
			fda_q <= ~p2_q.an_enable | p2_an_failed_i;
			ffd_q <= (~p2_q.an_enable | p2_an_failed_i) & p2_q.full_duplex;
		end
	end

	assign wb_ack_o               = ack_q;
	assign wb_dat_o               = dat_q;
	assign adv_o                  = adv_q;
	assign p2_ctrl_o              = p2_q;
	assign forced_speed_active_o  = fsa_q;
	assign forced_speed_100_o     = fs100_q;
	assign forced_duplex_active_o = fda_q;
	assign forced_full_duplex_o   = ffd_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_rd(logic [5:0] i);
		wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i && hit(idx, i);
	endsequence

	sequence s_wr(logic [5:0] i);
		wr_fire && hit(idx, i);
	endsequence

	chk_id_high_fixed: assert property (s_rd(`IDX_P1_ID_HIGH) |-> wb_dat_o == {16'h0000, ID_HIGH})
		else $error("identifier word wrong");
	chk_adv_reset_ones: assert property (disable iff (1'b0) rst_i |=> adv_q == 5'h1F && rsvd9_q == 1'b0)
		else $error("advertisement reset wrong");
	chk_adv_pause_wr: assert property (s_wr(`IDX_P1_ADVERTISE) ##0 wb_sel_i[1] |=> adv_o.pause == $past(wb_dat_i[10]))
		else $error("pause write lost");
	chk_adv_100_wr: assert property (s_wr(`IDX_P1_ADVERTISE) ##0 (wb_sel_i[1] && wb_sel_i[0])
		|=> adv_o.fd100 == $past(wb_dat_i[8]) && adv_o.hd100 == $past(wb_dat_i[7]))
		else $error("100 Mbps advertise write lost");
	chk_adv_10_wr: assert property (s_wr(`IDX_P1_ADVERTISE) ##0 wb_sel_i[0]
		|=> adv_o.fd10 == $past(wb_dat_i[6]) && adv_o.hd10 == $past(wb_dat_i[5]))
		else $error("10 Mbps advertise write lost");
	chk_alias_adv_wr: assert property (s_wr(`IDX_P1_CTRL_ALIAS) ##0 wb_sel_i[0] |=> adv_o == $past(wb_dat_i[4:0]))
		else $error("control alias write lost");
	chk_partner_view: assert property (s_rd(`IDX_P1_PARTNER) |-> wb_dat_o[15:11] == 5'h00
		&& wb_dat_o[9] == 1'b0 && wb_dat_o[4:0] == 5'h01 && wb_dat_o[10] == partner_q.pause)
		else $error("partner word layout wrong");
	chk_partner_mirror: assert property (s_rd(`IDX_P1_STAT_ALIAS) |-> wb_dat_o[4:0] == partner_q
		&& wb_dat_o[15:5] == 11'h000)
		else $error("status alias differs from partner view");
	chk_loopback_wr: assert property (s_wr(`IDX_P2_BASIC_CTRL) ##0 wb_sel_i[1]
		|=> p2_ctrl_o.loopback == $past(wb_dat_i[14]))
		else $error("loopback write lost");
	chk_p2_reset: assert property (disable iff (1'b0) rst_i |=> p2_ctrl_o.an_enable && p2_ctrl_o.crossover_style_select
		&& !p2_ctrl_o.force_mdix && !p2_ctrl_o.disable_mdix && !p2_ctrl_o.disable_tx)
		else $error("port 2 control reset wrong");
	chk_restart_pulse: assert property (s_wr(`IDX_P2_BASIC_CTRL) ##0 (wb_sel_i[1] && wb_dat_i[9])
		|=> p2_ctrl_o.restart ##1 !p2_ctrl_o.restart)
		else $error("restart not a single pulse");
	chk_style_alias: assert property (s_wr(`IDX_P2_STAT_ALIAS) ##0 wb_sel_i[1]
		|=> p2_ctrl_o.crossover_style_select == $past(wb_dat_i[15]))
		else $error("style alias write lost");
	chk_txdis_alias: assert property (s_wr(`IDX_P2_CTRL_ALIAS) ##0 wb_sel_i[1]
		|=> p2_ctrl_o.disable_tx == $past(wb_dat_i[14]) && p2_ctrl_o.disable_mdix == $past(wb_dat_i[10]))
		else $error("control alias write lost");
	chk_basic_rsvd_zero: assert property (s_rd(`IDX_P2_BASIC_CTRL) |-> wb_dat_o[15] == 1'b0 && wb_dat_o[10] == 1'b0
		&& wb_dat_o[7:6] == 2'b00 && wb_dat_o[3] == p2_q.disable_mdix && wb_dat_o[4] == p2_q.force_mdix)
		else $error("basic control read wrong");
	chk_forced_speed: assert property (!p2_q.an_enable && p2_q.force_100 |=> forced_speed_100_o)
		else $error("forced speed not applied");
	chk_forced_duplex: assert property (p2_q.an_enable && p2_an_failed_i && p2_q.full_duplex
		|=> forced_full_duplex_o && !forced_speed_active_o)
		else $error("forced duplex gating wrong");
endmodule
`default_nettype wire

// ===== dv/phy_mii_register_view_tb_top.sv
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
	$display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module phy_mii_register_view_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Value is arbitrary
	localparam logic [15:0] ID_VAL = 16'h3C5A;
	localparam logic [7:0]  A_BC   = 8'h00;
	localparam logic [7:0]  A_ID   = 8'h18;
	localparam logic [7:0]  A_ADV  = 8'h20;
	localparam logic [7:0]  A_LP   = 8'h28;
	localparam logic [7:0]  A_P1C  = 8'h40;
	localparam logic [7:0]  A_P1S  = 8'h44;
	localparam logic [7:0]  A_P2C  = 8'h48;
	localparam logic [7:0]  A_P2S  = 8'h4C;
	logic                   clk_i;
	logic                   rst_i;
	logic                   wb_cyc_i;
	logic                   wb_stb_i;
	logic                   wb_we_i;
	logic [7:0]             wb_adr_i;
	logic [3:0]             wb_sel_i;
	logic [31:0]            wb_dat_i;
	logic                   wb_ack_o;
	logic [31:0]            wb_dat_o;
	phy_mii_pkg::ability_s  p1_partner_i;
	logic                   p2_an_failed_i;
	phy_mii_pkg::ability_s  adv_o;
	phy_mii_pkg::p2_ctrl_s  p2_ctrl_o;
	logic [3:0]             forced;
	int                     fails;
	int                     checks_done;
	int                     restarts;
	int                     adv_pos [5] = '{5, 6, 7, 8, 10};
	int                     bc_pos [12] = '{0, 1, 2, 3, 4, 5, 8, 9, 11, 12, 13, 14};

	phy_mii_register_view #(.ID_HIGH(ID_VAL)) dut (
		.clk_i                  (clk_i),
		.rst_i                  (rst_i),
		.wb_cyc_i               (wb_cyc_i),
		.wb_stb_i               (wb_stb_i),
		.wb_we_i                (wb_we_i),
		.wb_adr_i               (wb_adr_i),
		.wb_sel_i               (wb_sel_i),
		.wb_dat_i               (wb_dat_i),
		.wb_ack_o               (wb_ack_o),
		.wb_dat_o               (wb_dat_o),
		.p1_partner_i           (p1_partner_i),
		.p2_an_failed_i         (p2_an_failed_i),
		.adv_o                  (adv_o),
		.p2_ctrl_o              (p2_ctrl_o),
		.forced_speed_active_o  (forced[3]),
		.forced_speed_100_o     (forced[2]),
		.forced_duplex_active_o (forced[1]),
		.forced_full_duplex_o   (forced[0])
	);

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Counting pulses shows one write gives exactly one restart
	always @(posedge clk_i) begin
		if (p2_ctrl_o.restart === 1'b1)
			restarts <= restarts + 1;
	end

	task automatic stop_test();
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Called just after a rising edge; returns one idle cycle after the ack edge
	task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 50)
			fails++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, adr, 4'h3, {16'h0000, d}, q);
	endtask

	task automatic rd(input string nm, input logic [7:0] adr, input logic [15:0] exp);
		logic [31:0] q;
		bus(1'b0, adr, 4'h3, 32'h0000_0000, q);
		`CHK(nm, {16'h0000, exp}, q)
	endtask

	initial begin
		repeat (5000) @(posedge clk_i);
		fails++;
		stop_test();
	end

	initial begin
		logic [31:0] q;
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		p1_partner_i = 5'h00;
		p2_an_failed_i = 1'b0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd("id_high", A_ID, ID_VAL);
		rd("adv_reset", A_ADV, 16'h05E1);
		`CHK("adv_o_reset", 5'h1F, adv_o)
		rd("partner_reset", A_LP, 16'h0001);
		rd("bc_reset", A_BC, 16'h1020);
		`CHK("p2_ctrl_reset", 12'h220, p2_ctrl_o)
		wr(A_ID, 16'hFFFF);
		rd("id_after_write", A_ID, ID_VAL);
		// Each advertised ability alone, seen in both views
		for (int i = 0; i < 5; i++) begin
			wr(A_ADV, 16'(1 << adv_pos[i]));
			`CHK("adv_o_bit", 5'(1 << i), adv_o)
			rd("p1_ctrl_alias", A_P1C, 16'(1 << i));
			rd("adv_bit", A_ADV, 16'(1 << adv_pos[i]) | 16'h0001);
		end
		wr(A_P1C, 16'h001F);
		rd("adv_from_alias", A_ADV, 16'h05E1);
		p1_partner_i <= 5'h16;
		repeat (2) @(posedge clk_i);
		wr(A_LP, 16'h0000);
		rd("partner_a", A_LP, 16'h04C1);
		rd("p1_stat_a", A_P1S, 16'h0016);
		p1_partner_i <= 5'h09;
		repeat (2) @(posedge clk_i);
		rd("partner_b", A_LP, 16'h0121);
		rd("p1_stat_b", A_P1S, 16'h0009);
		// Restart is masked out since it only pulses
		for (int i = 0; i < 12; i++) begin
			wr(A_BC, 16'(1 << bc_pos[i]));
			@(posedge clk_i);
			`CHK("p2_ctrl_bit", 12'(1 << i) & 12'hF7F, p2_ctrl_o)
			rd("bc_bit", A_BC, (i == 7) ? 16'h0000 : 16'(1 << bc_pos[i]));
		end
		`CHK("restart_once", 1, restarts)
		wr(A_BC, 16'hFFFF);
		rd("bc_all", A_BC, 16'h793F);
		`CHK("restart_twice", 2, restarts)
		`CHK("p2_ctrl_all", 12'hF7F, p2_ctrl_o)
		rd("p2_ctrl_alias", A_P2C, 16'hDFE0);
		rd("p2_stat_alias", A_P2S, 16'h8000);
		wr(A_P2C, 16'h0000);
		rd("bc_from_ctrl", A_BC, 16'h0020);
		wr(A_P2S, 16'h0000);
		rd("bc_from_stat", A_BC, 16'h0000);
		bus(1'b1, A_BC, 4'h1, 32'h0000_FFFF, q);
		rd("bc_low_lane", A_BC, 16'h003F);
		wr(A_BC, 16'h2100);
		repeat (2) @(posedge clk_i);
		`CHK("forced_an_off", 4'hF, forced)
		wr(A_BC, 16'h0000);
		repeat (2) @(posedge clk_i);
		`CHK("forced_10_half", 4'hA, forced)
		wr(A_BC, 16'h1100);
		repeat (2) @(posedge clk_i);
		`CHK("forced_an_on", 4'h0, forced)
		p2_an_failed_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		`CHK("forced_an_failed", 4'h3, forced)
		rd("unmapped", 8'hFC, 16'h0000);
		stop_test();
	end
endmodule
`default_nettype wire
